// >>> src/flash_host_ctrl.sv
// host controller that drives a byte-mode boot-sector flash through its pins.
// assumes an avalon-mm master on clk, and a flash whose ready/busy line is pulled up externally.
//
// How it works
// - unlock cycles drive only low bits AAA/555; upper address bits are driven zero.
// - a plain read op is one read cycle, no unlock writes first.
// - reset op writes F0 once; leaves identification and cfi modes.
// - identification ops write AA@AAA, 55@555, 90@AAA, then read.
// - the part code is fetched with three read cycles.
// - secured region entry writes AA, 55, 88.
// - secured region exit writes AA, 55, 90, then 00.
// - program writes AA, 55, A0, then data; address held across the whole strobe.
// - bypass entry writes AA, 55, 20; bypass programs need it first.
// - in bypass, program is A0 then the data write.
// - bypass is left only by 90 then 00.
// - erase writes AA, 55, 80, AA, 55, then 10 at AAA or 30 at the sector.
// - suspend is one write of B0.
//
// Local design decisions: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module flash_host_ctrl
  import flash_host_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output flash_out_t       flash_o,
  input  wire logic [7:0]  flash_dq_i,
  input  wire logic        flash_ready_busy_n_i
);

`include "flash_host_defs.svh"

  // ****************************************
  // declarations
  // ****************************************
  seq_state_t  state_q;
  op_t         op_q;
  logic [2:0]  step_q;
  logic [8:0]  cnt_q;
  logic [20:0] addr_q;
  logic [7:0]  wdata_q;
  logic [23:0] rdata_q;
  logic        byp_q, id_q, susp_q, erasing_q, cfi_q, ss_q, refused_q, tmo_q;
  logic [7:0]  dq_sync;
  logic        rb_sync;
  logic        bus_take, ctrl_wr, refuse, busy;
  logic        rb_prev_q;
  logic [8:0]  susp_run_q;
  logic [`ST_WIDTH-1:0] status;
  step_t       cur;
  op_t         new_op;

  // pin inputs cross in through the three-stage synchroniser
  pin_sync #(.W(9)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin_i ({flash_ready_busy_n_i, flash_dq_i}),
    .val_q ({rb_sync, dq_sync})
  );

  // ****************************************
  // command sequence table
  // ****************************************
  function automatic step_t mk(logic [20:0] a, logic [7:0] d, logic rd, logic last);
    step_t r;
    r.addr = a;
    r.data = d;
    r.rd   = rd;
    r.last = last;
    return r;
  endfunction

  function automatic step_t seq_step(op_t op, logic [2:0] s, logic byp, logic [20:0] a, logic [7:0] d);
    step_t      r;
    logic       unl;
    logic [2:0] j;
    unl = !(op inside {OP_READ, OP_RESET, OP_SUSPEND, OP_RESUME, OP_CFI, OP_BYP_EXIT}) &&
          !(op == OP_PROG && byp);
    j = unl ? s - 3'd2 : s;
    r = mk(`A_ZERO, `C_ZERO, 1'b0, 1'b1);
    if (unl && s == 3'd0) begin
      r = mk(`A_UNLOCK1, `C_UNLOCK1, 1'b0, 1'b0);
    end else if (unl && s == 3'd1) begin
      r = mk(`A_UNLOCK2, `C_UNLOCK2, 1'b0, 1'b0);
    end else begin
      unique case (op)
        OP_READ:       r = mk(a, `C_ZERO, 1'b1, 1'b1);
        OP_RESET:      r = mk(`A_ZERO, `C_RESET, 1'b0, 1'b1);
        OP_ID_MAKER, OP_ID_PART, OP_ID_SECT, OP_ID_SECSIL: begin
          if (j == 3'd0) begin
            r = mk(`A_UNLOCK1, `C_IDENT, 1'b0, 1'b0);
          end else if (op == OP_ID_MAKER) begin
            r = mk(`ID_MAKER_OFS, `C_ZERO, 1'b1, 1'b1);
          end else if (op == OP_ID_SECSIL) begin
            r = mk(`ID_SECSIL_OFS, `C_ZERO, 1'b1, 1'b1);
          end else if (op == OP_ID_SECT) begin
            r = mk(`ID_SECT_OFS | {a[`SECT_MSB:`SECT_LSB], 16'h0000}, `C_ZERO, 1'b1, 1'b1);
          end else begin
            unique case (j)
              3'd1:    r = mk(`ID_PART_OFS1, `C_ZERO, 1'b1, 1'b0);
              3'd2:    r = mk(`ID_PART_OFS2, `C_ZERO, 1'b1, 1'b0);
              default: r = mk(`ID_PART_OFS3, `C_ZERO, 1'b1, 1'b1);
            endcase
          end
        end
        OP_SS_ENTER:   r = mk(`A_UNLOCK1, `C_SECSIL, 1'b0, 1'b1);
        OP_SS_EXIT:    r = (j == 3'd0) ? mk(`A_UNLOCK1, `C_IDENT, 1'b0, 1'b0)
                                       : mk(`A_ZERO, `C_ZERO, 1'b0, 1'b1);
        OP_PROG:       r = (j == 3'd0) ? mk(byp ? `A_ZERO : `A_UNLOCK1, `C_PROGRAM, 1'b0, 1'b0)
                                       : mk(a, d, 1'b0, 1'b1);
        OP_BYP_ENTER:  r = mk(`A_UNLOCK1, `C_BYPASS, 1'b0, 1'b1);
        OP_BYP_EXIT:   r = (j == 3'd0) ? mk(`A_ZERO, `C_IDENT, 1'b0, 1'b0)
                                       : mk(`A_ZERO, `C_ZERO, 1'b0, 1'b1);
        OP_CHIP_ERASE, OP_SECT_ERASE: begin
          unique case (j)
            3'd0:    r = mk(`A_UNLOCK1, `C_ERASE, 1'b0, 1'b0);
            3'd1:    r = mk(`A_UNLOCK1, `C_UNLOCK1, 1'b0, 1'b0);
            3'd2:    r = mk(`A_UNLOCK2, `C_UNLOCK2, 1'b0, 1'b0);
            default: r = (op == OP_CHIP_ERASE) ? mk(`A_UNLOCK1, `C_CHIP, 1'b0, 1'b1)
                                               : mk(a, `C_SECT, 1'b0, 1'b1);
          endcase
        end
        OP_SUSPEND:    r = mk(`A_ZERO, `C_SUSPEND, 1'b0, 1'b1);
        OP_RESUME:     r = mk(`A_ZERO, `C_RESUME, 1'b0, 1'b1);
        OP_CFI:        r = mk(`A_CFI, `C_CFI, 1'b0, 1'b1);
      endcase
    end
    return r;
  endfunction

  // ****************************************
  // register bus decode
  // ****************************************
  // one wait cycle per access; the request is acted on at the edge waitrequest is seen low
  assign bus_take = (avs_read || avs_write) && !avs_waitrequest;
  assign ctrl_wr  = bus_take && avs_write && avs_address == `REG_CTRL;
  assign busy     = state_q != ST_IDLE;
  assign new_op   = op_t'(avs_writedata[3:0]);
  assign cur      = seq_step(op_q, step_q, byp_q, addr_q, wdata_q);

  // ops that the part would not take in its present mode never reach the pins
  always_comb begin
    refuse = busy;
    if (byp_q && !(new_op inside {OP_READ, OP_PROG, OP_BYP_EXIT, OP_SUSPEND, OP_RESUME})) begin
      refuse = 1'b1;
    end
    if (new_op == OP_BYP_EXIT && !byp_q) begin
      refuse = 1'b1;
    end
    if (new_op == OP_SUSPEND && !erasing_q) begin
      refuse = 1'b1;
    end
    if (new_op == OP_RESUME && !susp_q) begin
      refuse = 1'b1;
    end
    if (new_op == OP_CFI && (byp_q || susp_q || erasing_q)) begin
      refuse = 1'b1;
    end
    if (susp_q && new_op inside {OP_CHIP_ERASE, OP_SECT_ERASE}) begin
      refuse = 1'b1;
    end
  end

  assign status = {ss_q, cfi_q, tmo_q, refused_q, susp_q, id_q, byp_q, rb_sync, busy};

  // waitrequest and read data come from flops, answer one cycle after the request
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      unique case (avs_address)
        `REG_CTRL:   avs_readdata <= {28'h000_0000, op_q};
        `REG_ADDR:   avs_readdata <= {11'h000, addr_q};
        `REG_WDATA:  avs_readdata <= {24'h00_0000, wdata_q};
        `REG_STATUS: avs_readdata <= {23'h00_0000, status};
        `REG_RDATA:  avs_readdata <= {8'h00, rdata_q};
        default:     avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // address and write data registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      addr_q  <= `A_ZERO;
      wdata_q <= `C_ZERO;
    end else if (bus_take && avs_write && !busy) begin
      if (avs_address == `REG_ADDR) begin
        addr_q <= avs_writedata[20:0];
      end
      if (avs_address == `REG_WDATA) begin
        wdata_q <= avs_writedata[7:0];
      end
    end
  end

  // refused flag: write one to clear, a new refusal in the same cycle wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      refused_q <= 1'b0;
    end else if (ctrl_wr && refuse) begin
      refused_q <= 1'b1;
    end else if (bus_take && avs_write && avs_address == `REG_STATUS && avs_writedata[`ST_REFUSED]) begin
      refused_q <= 1'b0;
    end
  end

  // ****************************************
  // pin sequencer
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      op_q    <= OP_READ;
      step_q  <= 3'd0;
      cnt_q   <= 9'd0;
      flash_o <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: `A_ZERO, dq_o: `C_ZERO, dq_oe: 1'b0};
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (ctrl_wr && !refuse) begin
            op_q    <= new_op;
            step_q  <= 3'd0;
            state_q <= ST_SETUP;
          end
        end
        // address, chip select low and the falling strobe are all driven at the same edge
        ST_SETUP: begin
          flash_o.ce_n  <= 1'b0;
          flash_o.addr  <= cur.addr;
          flash_o.dq_o  <= cur.data;
          flash_o.dq_oe <= !cur.rd;
          flash_o.we_n  <= cur.rd;
          flash_o.oe_n  <= !cur.rd;
          cnt_q         <= cur.rd ? 9'(`RD_CYC) : 9'(`WP_CYC);
          state_q       <= ST_STROBE;
        end
        ST_STROBE: begin
          if (cnt_q == 9'd1) begin
            flash_o.we_n <= 1'b1;
            flash_o.oe_n <= 1'b1;
            state_q      <= ST_HOLD;
          end else begin
            cnt_q <= cnt_q - 9'd1;
          end
        end
        // data and chip select stay one cycle past the rising strobe, then release
        ST_HOLD: begin
          flash_o.ce_n  <= 1'b1;
          flash_o.dq_oe <= 1'b0;
          if (!cur.last) begin
            step_q  <= step_q + 3'd1;
            state_q <= ST_SETUP;
          end else if (op_q == OP_SUSPEND) begin
            cnt_q   <= 9'(`SUSP_CYC);
            state_q <= ST_SUSP;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        // the part may need the full halt time before it answers again
        ST_SUSP: begin
          if (cnt_q == 9'd1) begin
            state_q <= ST_IDLE;
          end
          cnt_q <= cnt_q - 9'd1;
        end
      endcase
    end
  end

  // read data capture; part code bytes shift in, the oldest on top
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_q <= 24'h00_0000;
      tmo_q   <= 1'b0;
    end else if (state_q == ST_STROBE && cur.rd && cnt_q == 9'd1) begin
      rdata_q <= (op_q == OP_ID_PART) ? {rdata_q[15:0], dq_sync} : {16'h0000, dq_sync};
      tmo_q   <= dq_sync[`DQ_TIMEOUT_BIT];
    end
  end

  // ready pin history; the synchronised pin lags the strobe, so a level test would end an erase at once
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rb_prev_q <= 1'b1;
    end else begin
      rb_prev_q <= rb_sync;
    end
  end

  // ****************************************
  // mode tracking, updated as the last cycle of a sequence ends; the erase flag clears on the rising ready pin
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      byp_q     <= 1'b0;
      id_q      <= 1'b0;
      susp_q    <= 1'b0;
      erasing_q <= 1'b0;
      cfi_q     <= 1'b0;
      ss_q      <= 1'b0;
    end else begin
      if (erasing_q && !susp_q && rb_sync && !rb_prev_q) begin
        erasing_q <= 1'b0;                                              // part reports ready again
      end
      if (state_q == ST_HOLD && cur.last) begin
        unique case (op_q)
          OP_RESET: begin
            id_q  <= 1'b0;
            cfi_q <= 1'b0;
          end
          OP_ID_MAKER, OP_ID_PART, OP_ID_SECT, OP_ID_SECSIL: id_q <= 1'b1;
          OP_SS_ENTER:   ss_q      <= 1'b1;
          OP_SS_EXIT:    ss_q      <= 1'b0;
          OP_BYP_ENTER:  byp_q     <= 1'b1;
          OP_BYP_EXIT:   byp_q     <= 1'b0;
          OP_SECT_ERASE: erasing_q <= 1'b1;
          OP_SUSPEND:    susp_q    <= 1'b1;
          OP_RESUME:     susp_q    <= 1'b0;
          OP_CFI:        cfi_q     <= 1'b1;
          default:       cfi_q     <= cfi_q;
        endcase
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  // cycles spent in the halt wait, counted so the wait length can be checked without a long delay
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      susp_run_q <= 9'd0;
    end else if (state_q == ST_SUSP) begin
      susp_run_q <= susp_run_q + 9'd1;
    end else if (state_q == ST_HOLD) begin
      susp_run_q <= 9'd0;
    end
  end

  AST_STROBE_EXCL: assert property (@(posedge clk) disable iff (!rst_b)
    !(!flash_o.we_n && !flash_o.oe_n)) else $error("write and read strobe low together");
  AST_NO_CONTENTION: assert property (@(posedge clk) disable iff (!rst_b)
    flash_o.dq_oe |-> flash_o.oe_n) else $error("data driven while output enabled");
  AST_UNLOCK_FIRST: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == ST_SETUP && step_q == 3'd0 && op_q inside {OP_ID_MAKER, OP_SS_ENTER, OP_CHIP_ERASE})
    |=> flash_o.addr == `A_UNLOCK1 && flash_o.dq_o == `C_UNLOCK1) else $error("bad first unlock cycle");
  AST_RESET_CODE: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == ST_SETUP && op_q == OP_RESET) |=> !flash_o.we_n[*3] ##1 flash_o.we_n && flash_o.dq_o == `C_RESET)
    else $error("reset write malformed");
  AST_ADDR_HELD: assert property (@(posedge clk) disable iff (!rst_b)
    (!flash_o.we_n && $past(!flash_o.we_n)) |-> $stable(flash_o.addr)) else $error("address moved in strobe");
  AST_DATA_PAST_RISE: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(flash_o.we_n) |-> flash_o.dq_oe && $stable(flash_o.dq_o) ##1 !flash_o.dq_oe)
    else $error("write data not held over strobe rise");
  AST_BYPASS_SHORT: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == ST_SETUP && op_q == OP_PROG && byp_q && step_q == 3'd0) |=> flash_o.dq_o == `C_PROGRAM)
    else $error("bypass program does not start with program code");
  AST_SUSP_WAIT: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == ST_HOLD && op_q == OP_SUSPEND) |=> state_q == ST_SUSP)
    else $error("suspend halt wait not entered");
  AST_SUSP_LEN: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q != ST_SUSP && $past(state_q) == ST_SUSP) |-> state_q == ST_IDLE && susp_run_q == 9'(`SUSP_CYC))
    else $error("suspend halt wait wrong length");
  AST_BUS_ANSWER: assert property (@(posedge clk) disable iff (!rst_b)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("bus answer late");
  AST_RESUME_ONLY_SUSP: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl_wr && new_op == OP_RESUME && !susp_q) |=> state_q == ST_IDLE && refused_q)
    else $error("resume issued while not suspended");

endmodule

`default_nettype wire

// >>> src/flash_host_defs.svh
// constants for the byte-mode flash command host: register map, command codes, timing.
// assumes a 25 MHz clock and a flash part wired in byte mode with 21 address lines.
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

// ****************************************
// register map (byte offsets)
// ****************************************
`define REG_CTRL        5'h00
`define REG_ADDR        5'h04
`define REG_WDATA       5'h08
`define REG_STATUS      5'h0c
`define REG_RDATA       5'h10

// ****************************************
// status bit positions
// ****************************************
`define ST_BUSY         0
`define ST_READY        1
`define ST_BYPASS       2
`define ST_IDMODE       3
`define ST_SUSPENDED    4
`define ST_REFUSED      5
`define ST_TIMEOUT      6
`define ST_CFI          7
`define ST_SECSIL       8
`define ST_WIDTH        9
`define DQ_TIMEOUT_BIT  5

// ****************************************
// cycle addresses and command codes
// ****************************************
`define A_UNLOCK1       21'h0_0aaa
`define A_UNLOCK2       21'h0_0555
`define A_CFI           21'h0_00aa
`define A_ZERO          21'h0_0000
`define ID_MAKER_OFS    21'h0_0000
`define ID_PART_OFS1    21'h0_0002
`define ID_PART_OFS2    21'h0_001c
`define ID_PART_OFS3    21'h0_001e
`define ID_SECT_OFS     21'h0_0004
`define ID_SECSIL_OFS   21'h0_0044
`define SECT_MSB        20
`define SECT_LSB        16
`define C_UNLOCK1       8'haa
`define C_UNLOCK2       8'h55
`define C_RESET         8'hf0
`define C_IDENT         8'h90
`define C_SECSIL        8'h88
`define C_ZERO          8'h00
`define C_PROGRAM       8'ha0
`define C_BYPASS        8'h20
`define C_ERASE         8'h80
`define C_CHIP          8'h10
`define C_SECT          8'h30
`define C_SUSPEND       8'hb0
`define C_RESUME        8'h30
`define C_CFI           8'h98

// ****************************************
// timing
// ****************************************
`define CLK_MHZ         25
`define CLK_NS          40
`define T_WP_NS         120
`define T_RD_NS         200
`define T_SUSP_US       15
`define WP_CYC          ((`T_WP_NS + `CLK_NS - 1) / `CLK_NS)
`define RD_CYC          ((`T_RD_NS + `CLK_NS - 1) / `CLK_NS)
`define SUSP_CYC        (`T_SUSP_US * `CLK_MHZ)

`endif

// >>> src/flash_host_pkg.sv
// types shared by the flash command host: operations, states, bus steps, pin bundle.
// assumes flash_host_defs.svh is on the include path.
package flash_host_pkg;

  // host operations launched by a write to the control register
  typedef enum logic [3:0] {
    OP_READ, OP_RESET, OP_ID_MAKER, OP_ID_PART, OP_ID_SECT, OP_ID_SECSIL, OP_SS_ENTER, OP_SS_EXIT,
    OP_PROG, OP_BYP_ENTER, OP_BYP_EXIT, OP_CHIP_ERASE, OP_SECT_ERASE, OP_SUSPEND, OP_RESUME, OP_CFI
  } op_t;

  // pin sequencer states, gray along idle-setup-strobe-hold
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_STROBE = 3'b011,
    ST_HOLD   = 3'b010,
    ST_SUSP   = 3'b110
  } seq_state_t;

  // one bus cycle of a command sequence
  typedef struct packed {
    logic [20:0] addr;
    logic [7:0]  data;
    logic        rd;
    logic        last;
  } step_t;

  // outputs toward the flash pins
  typedef struct packed {
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic [20:0] addr;
    logic [7:0]  dq_o;
    logic        dq_oe;
  } flash_out_t;

endpackage

// >>> src/pin_sync.sv
// three-stage synchroniser for pins coming from outside the clock domain.
// assumes the pin may change at any time; the value is taken once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] val_q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // ****************************************
  // stages; the first stage feeds only the second
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept a change only when it has settled over two stages
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      val_q <= '0;
    end else if (s2_q == s3_q) begin
      val_q <= s3_q;
    end
  end

endmodule

`default_nettype wire

// >>> tb/flash_dev_model.sv
// device-side model of the byte-mode flash: command decoder, id table, busy timer.
// assumes the bench resolves the shared data pins and that ready/busy is pulled high.
`timescale 1ns/1ps
`default_nettype none

module flash_dev_model #(
  parameter logic [7:0] MAKER = 8'h5e, // arbitrary id values
  parameter logic [7:0] P1    = 8'h7e,
  parameter logic [7:0] P2    = 8'h11,
  parameter logic [7:0] P3    = 8'h02,
  parameter logic [4:0] PSECT = 5'h03  // the one protected sector group
) (
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [20:0] addr,
  input  wire logic [7:0]  dq_i,
  output logic      [7:0]  dq_o,
  output logic             rb_n
);
  logic [7:0] mem [0:255];
  logic [7:0] q, last;
  logic [3:0] st;
  logic       id, byp, ss, cfi, susp, ers, busy;
  int         tk;

  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    {st, id, byp, ss, cfi, susp, ers, busy} = '0;
    tk   = 0;
    last = 8'h00;
  end

  // erase timer; a stale timer is dropped so a suspend really halts the work
  task automatic go();
    tk++;
    busy = 1'b1;
    fork
      begin
        automatic int t = tk;
        #40000;
        if (t == tk) begin
          busy = 1'b0;
          ers  = 1'b0;
        end
      end
    join_none
  endtask

  // data taken on whichever strobe rises first; only low 12 address bits decode
  always @(posedge we_n or posedge ce_n) begin
    if (ce_n !== we_n) begin
      if (st == 6) begin mem[addr[7:0]] = dq_i; st = 0; end
      else if (st == 7) begin byp = (dq_i != 8'h00); st = 0; end
      else if (dq_i == 8'hf0) begin st = 0; id = 0; cfi = 0; end
      else if (st == 0 && byp && dq_i == 8'ha0) st = 6;
      else if (st == 0 && byp && dq_i == 8'h90) st = 7;
      else if (st == 0 && dq_i == 8'hb0 && ers) begin susp = 1; busy = 0; tk++; end
      else if (st == 0 && dq_i == 8'h30 && susp) begin susp = 0; go(); end
      else if (st == 0 && id && ss && dq_i == 8'h00) begin id = 0; ss = 0; end
      else if (st == 0 && addr[11:0] == 12'h0aa && dq_i == 8'h98 && !byp && !susp) cfi = 1;
      else if (dq_i == 8'haa && addr[11:0] == 12'haaa && (st == 0 || st == 3)) st = st + 1;
      else if (dq_i == 8'h55 && addr[11:0] == 12'h555 && (st == 1 || st == 4)) st = st + 1;
      else if (st == 2 && addr[11:0] == 12'haaa) begin
        st = 0;
        case (dq_i)
          8'h90: id = 1;
          8'h88: ss = 1;
          8'h20: byp = 1;
          8'ha0: st = 6;
          8'h80: st = 3;
          default: ;
        endcase
      end
      else if (st == 5 && dq_i == 8'h10 && addr[11:0] == 12'haaa) begin st = 0; go(); end
      else if (st == 5 && dq_i == 8'h30) begin st = 0; ers = 1; go(); end
      else st = 0;
    end
  end

  // plain reads need no command; identification table otherwise
  always @* begin
    if (id) begin
      case (addr[7:0])
        8'h00:   q = MAKER;
        8'h02:   q = P1;
        8'h1c:   q = P2;
        8'h1e:   q = P3;
        8'h04:   q = {7'h00, addr[20:16] == PSECT};
        8'h44:   q = 8'h01;
        default: q = 8'h00;
      endcase
    end else q = mem[addr[7:0]];
  end

  // released pins show the inverse of the last value, never a friendly copy
  always @(posedge oe_n) last = q;
  assign dq_o = (!ce_n && !oe_n) ? q : ~last;
  assign rb_n = ~busy;
endmodule
`default_nettype wire

// >>> tb/tb_flash_host_ctrl.sv
// self-checking bench: avalon tasks drive the flash host against the flash model.
// assumes flash_host_defs.svh on the include path and the model's default id values.
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_defs.svh"

module tb_flash_host_ctrl
  import flash_host_pkg::*;
;
  logic        clk, rst_b, avs_read, avs_write, avs_waitrequest, rb_n;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, s;
  logic [7:0]  dq_m, dq_w;
  flash_out_t  fo;
  int          bad_count, check_count;

  flash_host_ctrl flash_host_ctrl_inst (
    .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .flash_o(fo), .flash_dq_i(dq_w), .flash_ready_busy_n_i(rb_n));
  flash_dev_model flash_dev_model_inst (
    .ce_n(fo.ce_n), .we_n(fo.we_n), .oe_n(fo.oe_n), .addr(fo.addr), .dq_i(dq_w), .dq_o(dq_m), .rb_n(rb_n));
  // the host owns the data pins only while its enable is up
  assign dq_w = fo.dq_oe ? fo.dq_o : dq_m;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask

  // requests held until waitrequest is sampled low at a rising edge
  task wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  // bounded poll of one status bit
  task idle(input int b, input logic v);
    int n;
    n = 0;
    do begin
      rd(`REG_STATUS, s);
      n++;
    end while (s[b] !== v && n < 3000);
    chk({31'h0000_0000, s[b]}, {31'h0000_0000, v});
  endtask

  task op(input logic [3:0] c);
    wr(`REG_CTRL, {28'h000_0000, c});
    idle(`ST_BUSY, 1'b0);
  endtask

  task results();
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end

  initial begin
    {rst_b, avs_read, avs_write, avs_address, avs_writedata} = '0;
    bad_count   = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(`REG_STATUS, s);
    chk(s & 32'h0000_01fd, 32'h0000_0000);
    rd(5'h14, s);
    chk(s, 32'h0000_0000);
    $display("test reset done");
    wr(`REG_ADDR, 32'h001f_f012);
    wr(`REG_WDATA, 32'h0000_005a);
    op(4'h8);
    op(4'h0);
    rd(`REG_RDATA, s);
    chk(s & 32'h0000_00ff, 32'h0000_005a);
    $display("test program done");
    op(4'h2);
    rd(`REG_RDATA, s);
    chk(s & 32'h0000_00ff, 32'h0000_005e);
    op(4'h3);
    chk(s & 32'h0000_0008, 32'h0000_0008);
    rd(`REG_RDATA, s);
    chk(s & 32'h00ff_ffff, 32'h007e_1102);
    wr(`REG_ADDR, 32'h0003_0000);
    op(4'h4);
    rd(`REG_RDATA, s);
    chk(s & 32'h0000_00ff, 32'h0000_0001);
    wr(`REG_ADDR, 32'h0005_0000);
    op(4'h4);
    rd(`REG_RDATA, s);
    chk(s & 32'h0000_00ff, 32'h0000_0000);
    op(4'h5);
    rd(`REG_RDATA, s);
    chk(s & 32'h0000_00ff, 32'h0000_0001);
    op(4'h1);
    chk(s & 32'h0000_0008, 32'h0000_0000);
    $display("test identification done");
    op(4'h6);
    chk(s & 32'h0000_0100, 32'h0000_0100);
    op(4'h7);
    chk(s & 32'h0000_0100, 32'h0000_0000);
    op(4'hf);
    chk(s & 32'h0000_00a0, 32'h0000_0080);
    op(4'h1);
    chk(s & 32'h0000_0080, 32'h0000_0000);
    $display("test secured and query done");
    op(4'h9);
    chk(s & 32'h0000_0004, 32'h0000_0004);
    op(4'hf);
    chk(s & 32'h0000_00a0, 32'h0000_0020);
    wr(`REG_STATUS, 32'h0000_0020);
    wr(`REG_ADDR, 32'h0000_0034);
    wr(`REG_WDATA, 32'h0000_0033);
    op(4'h8);
    op(4'h0);
    chk(s & 32'h0000_0040, 32'h0000_0040);
    rd(`REG_RDATA, s);
    chk(s & 32'h0000_00ff, 32'h0000_0033);
    op(4'ha);
    chk(s & 32'h0000_0024, 32'h0000_0000);
    op(4'ha);
    chk(s & 32'h0000_0020, 32'h0000_0020);
    wr(`REG_STATUS, 32'h0000_0020);
    $display("test bypass done");
    wr(`REG_ADDR, 32'h0007_0000);
    op(4'hc);
    op(4'hd);
    chk(s & 32'h0000_0033, 32'h0000_0012);
    op(4'he);
    idle(`ST_READY, 1'b0);
    idle(`ST_READY, 1'b1);
    chk(s & 32'h0000_0032, 32'h0000_0002);
    op(4'he);
    chk(s & 32'h0000_0020, 32'h0000_0020);
    wr(`REG_STATUS, 32'h0000_0020);
    op(4'hb);
    op(4'hd);
    chk(s & 32'h0000_0030, 32'h0000_0020);
    $display("test erase done");
    results();
  end
endmodule
`default_nettype wire
